// [hdl/swpol_defs.svh]
// Register offsets, field positions and reset values of the forwarding-policy block.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
`ifndef SWPOL_DEFS_SVH
`define SWPOL_DEFS_SVH

`define SWPOL_OFS_PORT1 12'h000
`define SWPOL_OFS_PORT2 12'h004
`define SWPOL_OFS_PORTH 12'h008
`define SWPOL_OFS_GLOBAL 12'h00C
`define SWPOL_OFS_STATUS 12'h010

`define SWPOL_PC_LRN_DIS 0
`define SWPOL_PC_RX_EN 1
`define SWPOL_PC_TX_EN 2
`define SWPOL_PC_SNIFFER 5
`define SWPOL_PC_TX_SNIFF 6
`define SWPOL_PC_RX_SNIFF 7

`define SWPOL_GC_PASS_BAD 0
`define SWPOL_GC_MLD_OPT 12
`define SWPOL_GC_MLD_EN 13

`define SWPOL_PC_RESET 16'h0006
`define SWPOL_GC_RESET 16'h0000

`define SWPOL_IP_VER4 4'h4
`define SWPOL_IP_PROTO_IGMP 8'h02
`define SWPOL_HOP_ONE 8'h01
`define SWPOL_NH_HBH 8'h00
`define SWPOL_NH_ICMP 8'h01
`define SWPOL_NH_ICMPV6 8'h3A
`define SWPOL_NH_ROUTE 8'h2B
`define SWPOL_NH_FRAG 8'h2C
`define SWPOL_NH_ESP 8'h32
`define SWPOL_NH_AH 8'h33
`define SWPOL_NH_DEST 8'h3C

`define SWPOL_HOST_IDX 2
`define SWPOL_HOST_MASK 3'h4

`define SWPOL_RESP_OKAY 2'h0
`define SWPOL_RESP_SLVERR 2'h2

`endif

// [hdl/swpol_pkg.sv]
// Types shared by the forwarding-policy block and its per-port settings stage.
// Port masks are bit 0 = network port one, bit 1 = network port two, bit 2 = host port.
package swpol_pkg;

   typedef struct packed {
      logic rx_sniff;
      logic tx_sniff;
      logic sniffer;
      logic tx_en;
      logic rx_en;
      logic lrn_dis;
   } swpol_pcfg_t;

   typedef struct packed {
      logic [1:0] src;
      logic [2:0] lookup_mask;
      logic static_hit;
      logic static_ovr;
      logic [2:0] static_mask;
      logic bad;
      logic ip_encap;
      logic [3:0] ip_ver;
      logic [7:0] ip_proto;
      logic v6;
      logic v6_mcast;
      logic [7:0] hop_lim;
      logic [7:0] nxt_hdr;
      logic [7:0] hbh_nxt_hdr;
   } swpol_desc_t;

   typedef struct packed {
      logic [2:0] fwd_mask;
      logic learn;
      logic trapped;
      logic mirrored;
   } swpol_dec_t;

endpackage : swpol_pkg

// [hdl/swpol_port_cfg.sv]
// Holds the settings one port uses for frame decisions.
// Assumes frame_active is high from the first to the last cycle of any frame in flight.
`timescale 1ns/10ps

module swpol_port_cfg (
   input wire logic aclk,
   input wire logic aresetn,
   input swpol_pkg::swpol_pcfg_t soft_cfg,
   input wire logic frame_active,
   output swpol_pkg::swpol_pcfg_t act_cfg
);

   swpol_pkg::swpol_pcfg_t act_r;
   swpol_pkg::swpol_pcfg_t act_nxt;

   // RQ21 - boundary-only update. Software writes wait here so no frame sees mixed settings.
   assign act_nxt = frame_active ? act_r : soft_cfg;
   assign act_cfg = act_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_r <= '{rx_sniff: 1'b0, tx_sniff: 1'b0, sniffer: 1'b0,
                    tx_en: 1'b1, rx_en: 1'b1, lrn_dis: 1'b0};
      end else begin
         act_r <= act_nxt;
      end
   end

endmodule : swpol_port_cfg

// [hdl/swpol_top.sv]
// Forwarding-policy stage of a two-port switch with a host port, plus its AXI4-Lite registers.
// Assumes the address lookup supplies one descriptor per frame, on this clock, with no stall.
// Functional notes
// RQ1 - Host designated; network ports take five states.
// RQ2 - Disable: no traffic, no learning.
// RQ3 - Override static hits still reach host.
// RQ4 - Blocking: only processor-bound frames pass.
// RQ5 - Learning state enables learning only.
// RQ6 - Forwarding: normal traffic and learning.
// RQ7 - Processor never sends to disabled/blocking ports.
// RQ8 - Processor drops override frames when disabled.
// RQ9 - Processor loads override static entries.
// RQ10 - Processor may send in listening onward.
// RQ11 - IGMP frames trapped to host only.
// RQ12 - IGMP: IP version four, protocol two.
// RQ13 - Static multicast goes to listed ports.
// RQ14 - MLD enable bit 13, option 12.
// RQ15 - MLD: multicast, hop one, header 1/58.
// RQ16 - Option adds headers 43,44,50,51,60.
// RQ17 - Receive-sniff copies received frames to sniffer.
// RQ18 - Optionally mirror bad received frames too.
// RQ19 - Transmit-sniff copies transmitted frames to sniffer.
// RQ20 - Mirrored frame reaches both destinations.
// RQ21 - Settings change only between frames. Only the port settings are staged; the global register applies at once.
`timescale 1ns/10ps
`include "swpol_defs.svh"

module swpol_top #(
   parameter int CNT_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic frame_active,
   input wire logic desc_valid,
   input swpol_pkg::swpol_desc_t desc,
   output logic dec_valid,
   output swpol_pkg::swpol_dec_t dec
);

   if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
      $error("CNT_W must lie between 1 and 16");
   end

   // Register bus state.
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic aw_full_r, w_full_r;
   logic [11:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [15:0] port1_r, port2_r, porth_r, global_r;
   logic [CNT_W-1:0] frame_cnt_r;
   logic dec_valid_r;
   swpol_pkg::swpol_dec_t dec_r;

   wire aw_hs = s_axi_awvalid & awready_r;
   wire w_hs = s_axi_wvalid & wready_r;
   wire do_write = aw_full_r & w_full_r & ~bvalid_r;
   wire ar_hs = s_axi_arvalid & arready_r;
   wire [31:0] byte_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

   wire wr_p1 = do_write && awaddr_r == `SWPOL_OFS_PORT1;
   wire wr_p2 = do_write && awaddr_r == `SWPOL_OFS_PORT2;
   wire wr_ph = do_write && awaddr_r == `SWPOL_OFS_PORTH;
   wire wr_gc = do_write && awaddr_r == `SWPOL_OFS_GLOBAL;
   wire wr_st = do_write && awaddr_r == `SWPOL_OFS_STATUS;
   wire wr_hit = wr_p1 | wr_p2 | wr_ph | wr_gc | wr_st;

   function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] d,
                                         input logic [31:0] m);
      merge = (old_v & ~m[15:0]) | (d[15:0] & m[15:0]);
   endfunction : merge

   wire [15:0] port1_nxt = wr_p1 ? merge(port1_r, wdata_r, byte_mask) : port1_r;
   wire [15:0] port2_nxt = wr_p2 ? merge(port2_r, wdata_r, byte_mask) : port2_r;
   wire [15:0] porth_nxt = wr_ph ? merge(porth_r, wdata_r, byte_mask) : porth_r;
   wire [15:0] global_nxt = wr_gc ? merge(global_r, wdata_r, byte_mask) : global_r;

   // Effective settings of each port, staged so they only move between frames.
   swpol_pkg::swpol_pcfg_t soft_cfg [3];
   swpol_pkg::swpol_pcfg_t act_cfg [3];
   logic [15:0] port_regs [3];
   assign port_regs[0] = port1_r;
   assign port_regs[1] = port2_r;
   assign port_regs[2] = porth_r;

   // RQ1 - host port fixed open. Only the network ports carry transmit and receive enables.
   for (genvar p = 0; p < 3; p++) begin : g_port
      // The whole struct is driven at once so each element keeps a single driver.
      assign soft_cfg[p] = '{
         rx_sniff: port_regs[p][`SWPOL_PC_RX_SNIFF],
         tx_sniff: port_regs[p][`SWPOL_PC_TX_SNIFF],
         sniffer: port_regs[p][`SWPOL_PC_SNIFFER],
         tx_en: (p == `SWPOL_HOST_IDX) ? 1'b1 : port_regs[p][`SWPOL_PC_TX_EN],
         rx_en: (p == `SWPOL_HOST_IDX) ? 1'b1 : port_regs[p][`SWPOL_PC_RX_EN],
         lrn_dis: port_regs[p][`SWPOL_PC_LRN_DIS]
      };
      swpol_port_cfg u_cfg (
         .aclk(aclk),
         .aresetn(aresetn),
         .soft_cfg(soft_cfg[p]),
         .frame_active(frame_active),
         .act_cfg(act_cfg[p])
      );
   end

   wire [2:0] tx_en_v = {act_cfg[2].tx_en, act_cfg[1].tx_en, act_cfg[0].tx_en};
   wire [2:0] rx_en_v = {act_cfg[2].rx_en, act_cfg[1].rx_en, act_cfg[0].rx_en};
   wire [2:0] lrn_dis_v = {act_cfg[2].lrn_dis, act_cfg[1].lrn_dis, act_cfg[0].lrn_dis};
   wire [2:0] rx_sniff_v = {act_cfg[2].rx_sniff, act_cfg[1].rx_sniff, act_cfg[0].rx_sniff};
   wire [2:0] tx_sniff_v = {act_cfg[2].tx_sniff, act_cfg[1].tx_sniff, act_cfg[0].tx_sniff};
   wire [2:0] sniffer_v = {act_cfg[2].sniffer, act_cfg[1].sniffer, act_cfg[0].sniffer};

   // Source index 3 names no port, so such a descriptor is forwarded nowhere.
   wire src_ok = desc.src != 2'h3;
   wire [1:0] src_idx = src_ok ? desc.src : 2'h2;
   wire [2:0] src_oh = src_ok ? 3'(3'h1 << src_idx) : 3'h0;
   wire src_net = src_ok && src_idx != 2'(`SWPOL_HOST_IDX);
   wire rx_ok = src_ok & rx_en_v[src_idx];

   // RQ12 - IGMP classification.
   wire is_igmp = desc.ip_encap && desc.ip_ver == `SWPOL_IP_VER4 &&
                  desc.ip_proto == `SWPOL_IP_PROTO_IGMP;

   function automatic logic mld_hdr(input logic [7:0] h, input logic opt);
      // RQ15 - base next headers.
      mld_hdr = h == `SWPOL_NH_ICMP || h == `SWPOL_NH_ICMPV6 ||
                // RQ16 - optional extension headers.
                (opt && (h == `SWPOL_NH_ROUTE || h == `SWPOL_NH_FRAG || h == `SWPOL_NH_ESP ||
                         h == `SWPOL_NH_AH || h == `SWPOL_NH_DEST));
   endfunction : mld_hdr

   wire mld_en = global_r[`SWPOL_GC_MLD_EN];
   wire mld_opt = global_r[`SWPOL_GC_MLD_OPT];
   wire pass_bad = global_r[`SWPOL_GC_PASS_BAD];
   // RQ14 - MLD enable and option.
   // RQ15 - hop limit and headers.
   wire is_mld = mld_en && desc.v6 && desc.v6_mcast && desc.hop_lim == `SWPOL_HOP_ONE &&
                 (mld_hdr(desc.nxt_hdr, mld_opt) ||
                  (desc.nxt_hdr == `SWPOL_NH_HBH && mld_hdr(desc.hbh_nxt_hdr, mld_opt)));
   // RQ11 - snooped control frames trapped.
   wire trap = src_net & (is_igmp | is_mld);

   // RQ13 - static entry ports win.
   wire [2:0] base_mask = desc.static_hit ? desc.static_mask : desc.lookup_mask;
   // RQ6 - normal forwarding from network ports gated per port.
   wire [2:0] tx_gate = src_net ? tx_en_v : 3'h7;
   wire [2:0] norm_mask = trap ? `SWPOL_HOST_MASK : (base_mask & ~src_oh & tx_gate);
   // RQ3 - override hits reach host.
   // A descriptor that names no port gets no override copy either.
   wire ovr_hit = src_net & desc.static_hit & desc.static_ovr;
   wire [2:0] ovr_mask = ovr_hit ? (`SWPOL_HOST_MASK & ~src_oh) : 3'h0;
   // RQ2 - closed ports pass nothing else.
   // RQ4 - blocking passes processor frames only.
   wire [2:0] fwd_mask = desc.bad ? 3'h0 : (rx_ok ? norm_mask : ovr_mask);

   // RQ17 - receive mirror.
   // RQ18 - bad frames mirrored on option.
   wire rx_mirror = rx_ok & rx_sniff_v[src_idx] & (~desc.bad | pass_bad);
   // RQ19 - transmit mirror.
   wire tx_mirror = |(fwd_mask & tx_sniff_v);
   wire mirror = rx_mirror | tx_mirror;
   // RQ20 - both deliveries kept.
   wire [2:0] out_mask = fwd_mask | (mirror ? (sniffer_v & ~src_oh) : 3'h0);
   // RQ5 - learning follows disable bit.
   wire learn = src_ok & ~desc.bad & ~lrn_dis_v[src_idx];

   swpol_pkg::swpol_dec_t dec_nxt;
   assign dec_nxt = '{
      fwd_mask: out_mask,
      learn: learn,
      trapped: trap & rx_ok & ~desc.bad,
      mirrored: mirror & (|(sniffer_v & ~src_oh))
   };

   // Read decode.
   // Status shows the settings in force, which lag a write made during a frame.
   wire [31:0] status_word = {16'(frame_cnt_r),
                              7'h00, lrn_dis_v[1], rx_en_v[1], tx_en_v[1],
                              3'h0, lrn_dis_v[0], rx_en_v[0], tx_en_v[0]};
   wire rd_p1 = s_axi_araddr == `SWPOL_OFS_PORT1;
   wire rd_p2 = s_axi_araddr == `SWPOL_OFS_PORT2;
   wire rd_ph = s_axi_araddr == `SWPOL_OFS_PORTH;
   wire rd_gc = s_axi_araddr == `SWPOL_OFS_GLOBAL;
   wire rd_st = s_axi_araddr == `SWPOL_OFS_STATUS;
   wire [31:0] rd_word = rd_p1 ? {16'h0000, port1_r} :
                         rd_p2 ? {16'h0000, port2_r} :
                         rd_ph ? {16'h0000, porth_r} :
                         rd_gc ? {16'h0000, global_r} :
                         rd_st ? status_word : 32'h0000_0000;
   wire rd_hit = rd_p1 | rd_p2 | rd_ph | rd_gc | rd_st;

   // Write channel: address and data are caught separately, in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awaddr_r <= 12'h000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `SWPOL_RESP_OKAY;
      end else begin
         if (aw_hs) begin
            awaddr_r <= s_axi_awaddr;
            aw_full_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (w_hs) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_full_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (do_write) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? `SWPOL_RESP_OKAY : `SWPOL_RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // The status word is read-only; a write to it is accepted and has no effect.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port1_r <= `SWPOL_PC_RESET;
         port2_r <= `SWPOL_PC_RESET;
         porth_r <= `SWPOL_PC_RESET;
         global_r <= `SWPOL_GC_RESET;
      end else begin
         port1_r <= port1_nxt;
         port2_r <= port2_nxt;
         porth_r <= porth_nxt;
         global_r <= global_nxt;
      end
   end

   // Read data is caught at the address handshake, so it stands until it is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `SWPOL_RESP_OKAY;
      end else if (ar_hs) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_hit ? `SWPOL_RESP_OKAY : `SWPOL_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // One decision per descriptor, one cycle later; the count wraps.
   // The decision is zeroed between pulses so a stale mask is never shown.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dec_valid_r <= 1'b0;
         dec_r <= '0;
         frame_cnt_r <= '0;
      end else begin
         dec_valid_r <= desc_valid;
         dec_r <= desc_valid ? dec_nxt : '0;
         frame_cnt_r <= desc_valid ? frame_cnt_r + 1'b1 : frame_cnt_r;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign dec_valid = dec_valid_r;
   assign dec = dec_r;

endmodule : swpol_top

// [tb/swpol_assertions.sv]
// Port checks for the forwarding-policy block.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps

module swpol_assertions #(
   parameter int CNT_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic desc_valid,
   input swpol_pkg::swpol_desc_t desc,
   input wire logic dec_valid,
   input swpol_pkg::swpol_dec_t dec
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_dec_pulse: assert property (desc_valid |=> dec_valid)
      else $error("decision missing");
   chk_dec_quiet: assert property (!desc_valid |=> !dec_valid && dec == '0)
      else $error("stray decision");
   chk_trap_host: assert property (dec_valid && dec.trapped |-> dec.fwd_mask[2])
      else $error("trapped frame not at host");
   chk_src_none: assert property (desc_valid && desc.src == 2'h3 |=> dec == '0)
      else $error("sourceless frame forwarded");
   chk_bad_learn: assert property (desc_valid && desc.bad |=> !dec.learn)
      else $error("bad frame learned");
   chk_no_echo: assert property (desc_valid && desc.src != 2'h3 |=>
      (dec.fwd_mask & (3'h1 << $past(desc.src))) == 3'h0) else $error("sent back to source");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   chk_read_turn: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   chk_write_turn: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");

   cover property (dec_valid && dec.trapped);
   cover property (dec_valid && dec.mirrored);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : swpol_assertions

bind swpol_top swpol_assertions #(.CNT_W(CNT_W)) chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .desc_valid(desc_valid), .desc(desc), .dec_valid(dec_valid), .dec(dec));

// [tb/swpol_host_model.sv]
// Host processor behind the host port: picks targets, keeps frames delivered while a network port transmits.
// Assumes tx_open mirrors the transmit enables software set.
`timescale 1ns/10ps

module swpol_host_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] tx_open,
   input wire logic dec_valid,
   input swpol_pkg::swpol_dec_t dec,
   output logic [2:0] host_dst,
   output int kept
);
   assign host_dst = {1'b0, tx_open};
   always @(posedge aclk) begin
      if (!aresetn)
         kept <= 0;
      else if (dec_valid && dec.fwd_mask[2] && |tx_open)
         kept <= kept + 1;
   end
endmodule : swpol_host_model

// [tb/swpol_top_bench.sv]
// Self-checking bench: a reference model predicts every decision and register read.
// Assumes the design and host model files are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end

module swpol_top_bench;
   logic aclk = 0, aresetn = 0, frame_active = 0, desc_valid = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, st = 32'h0000_6BE6;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, dec_valid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] host_dst;
   swpol_pkg::swpol_desc_t desc = '0, d;
   swpol_pkg::swpol_dec_t dec, exq[$], exp_p, exp_d;
   logic [15:0] regm[4] = '{16'h0006, 16'h0006, 16'h0006, 16'h0000}, act[3];
   int err_total = 0, tests_run = 0, cyc = 0, ndesc = 0, hostn = 0, kept;
   localparam logic [7:0] NH[9] = '{0, 1, 58, 43, 44, 50, 51, 60, 6};
   localparam logic [15:0] P1[4] = '{16'h0001, 16'h0000, 16'h0006, 16'h00C6};
   localparam logic [15:0] GL[3] = '{16'h0000, 16'h2000, 16'h3000};

   swpol_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .frame_active(frame_active), .desc_valid(desc_valid),
      .desc(desc), .dec_valid(dec_valid), .dec(dec));
   swpol_host_model host (.aclk(aclk), .aresetn(aresetn), .tx_open({regm[1][2], regm[0][2]}),
      .dec_valid(dec_valid), .dec(dec), .host_dst(host_dst), .kept(kept));

   always #2 aclk = ~aclk;

   function automatic logic [31:0] rnd();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction : rnd

   function automatic logic okh(logic [7:0] x, logic o);
      return x == 1 || x == 58 || (o && (x == 43 || x == 44 || x == 50 || x == 51 || x == 60));
   endfunction : okh

   function automatic swpol_pkg::swpol_dec_t pred(swpol_pkg::swpol_desc_t f);
      swpol_pkg::swpol_dec_t r;
      logic [15:0] c;
      logic [2:0] sb;
      logic rx;
      logic mld;
      r = '0;
      if (f.src == 2'h3) return r;
      c = act[f.src];
      sb = 3'h1 << f.src;
      rx = f.src == 2'h2 || c[1];
      r.learn = !f.bad && !c[0];
      mld = regm[3][13] && f.v6 && f.v6_mcast && f.hop_lim == 8'h01 && (okh(f.nxt_hdr,
         regm[3][12]) || (f.nxt_hdr == 8'h00 && okh(f.hbh_nxt_hdr, regm[3][12])));
      r.trapped = rx && f.src != 2'h2 && (mld || (f.ip_encap && f.ip_ver == 4'h4 &&
         f.ip_proto == 8'h02));
      if (!rx) r.fwd_mask = {f.static_hit && f.static_ovr, 2'b00};
      else if (r.trapped) r.fwd_mask = 3'h4;
      else if (!f.bad) r.fwd_mask = (f.static_hit ? f.static_mask : f.lookup_mask) & ~sb &
         (f.src == 2'h2 ? 3'h7 : {1'b1, act[1][2], act[0][2]});
      r.mirrored = ((c[7] && rx && (!f.bad || regm[3][0])) ||
         |(r.fwd_mask & {act[2][6], act[1][6], act[0][6]})) &&
         |({act[2][5], act[1][5], act[0][5]} & ~sb);
      if (r.mirrored) r.fwd_mask |= {act[2][5], act[1][5], act[0][5]} & ~sb;
      return r;
   endfunction : pred

   function automatic swpol_pkg::swpol_desc_t mk();
      swpol_pkg::swpol_desc_t f;
      logic [31:0] r;
      logic [13:0] x;
      {x, f} = {rnd(), rnd()};
      r = rnd();
      f.bad = r[2:0] == 3'h0;
      if (r[3]) f.ip_ver = 4'h4;
      if (r[4]) f.ip_proto = 8'h02;
      if (r[5]) f.hop_lim = 8'h01;
      f.nxt_hdr = NH[r[11:8] % 9];
      f.hbh_nxt_hdr = NH[r[15:12] % 9];
      // Bad frames carry no trap or override, so their handling stays unambiguous.
      if (f.bad) {f.ip_encap, f.v6, f.static_ovr} = 3'h0;
      if (f.src == 2'h2) f.lookup_mask = host_dst;
      return f;
   endfunction : mk

   always @(posedge aclk) begin
      if (!aresetn) for (int i = 0; i < 3; i++) act[i] <= 16'h0006;
      else if (!frame_active) for (int i = 0; i < 3; i++) act[i] <= regm[i];
      if (aresetn && desc_valid) begin
         exp_p = pred(desc);
         exq.push_back(exp_p);
         ndesc++;
         if (exp_p.fwd_mask[2] && (regm[0][2] || regm[1][2])) hostn++;
      end
      if (dec_valid) begin
         exp_d = exq.pop_front();
         `CHK(dec, exp_d)
      end
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         test_done();
      end
   end

   task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      logic ad;
      logic wd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) ad = 1;
         if (s_axi_wvalid && s_axi_wready) wd = 1;
         if (ad) s_axi_awvalid <= 1'b0;
         if (wd) s_axi_wvalid <= 1'b0;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, er)
      if (er == 2'h0 && a < 12'h010) regm[a[3:2]] = v[15:0];
   endtask : axw

   task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      `CHK({s_axi_rresp, s_axi_rdata}, {er, e})
   endtask : axr

   task automatic send(input swpol_pkg::swpol_desc_t f);
      @(posedge aclk);
      desc_valid <= 1'b1;
      desc <= f;
   endtask : send

   task automatic idle();
      @(posedge aclk);
      desc_valid <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : idle

   function automatic logic [31:0] stat();
      return {ndesc[15:0], 7'h0, act[1][0], act[1][1], act[1][2], 3'h0, act[0][0], act[0][1],
         act[0][2]};
   endfunction : stat

   task automatic test_done();
      if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) axr(12'(4 * i), {16'h0, regm[i]}, 2'h0);
      axr(12'h010, 32'h0000_00C3, 2'h0);
      axr(12'h014, 32'h0000_0000, 2'h2);
      axw(12'h014, 32'h0000_0001, 2'h2);
      axw(12'h010, 32'h0000_FFFF, 2'h0);
      for (int s = 0; s < 12; s++) begin
         axw(12'h000, {16'h0, P1[s % 4]}, 2'h0);
         axw(12'h004, rnd() & 32'h0000_00E7, 2'h0);
         axw(12'h008, rnd() & 32'h0000_00E1, 2'h0);
         axw(12'h00C, {16'h0, GL[s / 4]} | (rnd() & 32'h1), 2'h0);
         axr(12'h000, {16'h0, P1[s % 4]}, 2'h0);
         repeat (40) send(mk());
         idle();
      end
      d = mk();
      d.src = 2'h0;
      @(posedge aclk) frame_active <= 1'b1;
      axw(12'h000, 32'h0000_0001, 2'h0);
      send(d);
      idle();
      axr(12'h010, stat(), 2'h0);
      @(posedge aclk) frame_active <= 1'b0;
      repeat (2) @(posedge aclk);
      send(d);
      idle();
      axr(12'h010, stat(), 2'h0);
      `CHK(exq.size(), 0)
      `CHK(kept, hostn)
      test_done();
   end
endmodule : swpol_top_bench
